// >>> inc/sbcwd_pkg.sv
// Constants and types of the serial control word decoder
// How it works
// - Command and answer words are fixed sixteen bits
// - Answer reports wake pin level frozen after last accepted frame
// - Mode code zero refused and flagged as a corrupted command; answers init
// - Code 001 restarts, only from software flash
// - Codes 010 and 011 enter flash, normal
// - Codes 100 and 101 enter sleep, stop
// - Code 110 fail-safe, only in development mode
// - Code 111 reads back same frame, no write
// - Init and restart also entered automatically
// - Select field picks register written and read
// - Interrupt held until cause register is read
// - All interrupt sources enabled after reset
// - CAN wake enable defaults one; flag on wake
// - LIN wake enable defaults one; flag on wake
// - Wake pin edge select and seen edges
// - Summary bit shows pending failure register content
// - Sample on falling, shift on rising, apply on deselect
// - Bad clock count: discard, flag, repeat answer
// - Forbidden mode change is a corrupted command
package sbcwd_pkg;

  // ------------------------------------------------------------
  // Word layout
  // ------------------------------------------------------------
  localparam int WORD_W      = 16;
  localparam int DATA_W      = 9;
  localparam int BIT_WD      = 15;
  localparam int BIT_WAKELVL = 15;
  localparam int MODE_HI     = 14;
  localparam int MODE_LO     = 12;
  localparam int SEL_HI      = 11;
  localparam int SEL_LO      = 9;
  localparam int NUM_REGS    = 8;
  // Fall count at which mode and select are complete
  localparam logic [3:0] HDR_FALL = 4'h6;

  // ------------------------------------------------------------
  // Wake interrupt register fields
  // ------------------------------------------------------------
  localparam int CAN_WAKE_ENABLE_BIT  = 0;
  localparam int WK_LIN_BIT  = 1;
  localparam int WK_EDGE_LO  = 2;
  localparam int WK_EDGE_HI  = 3;
  localparam int WK_CYC_BIT  = 4;
  localparam int WK_SUM_BIT  = 5;
  localparam int WK_REG_W    = 6;
  localparam logic       RST_CAN_EN = 1'b1;
  localparam logic       RST_LIN_EN = 1'b1;
  localparam logic [1:0] RST_EDGE   = 2'b11;
  localparam logic [1:0] EDGE_RISE  = 2'b10;
  localparam logic [1:0] EDGE_FALL  = 2'b01;
  // Serial failure position in the device failure register
  localparam int         SPI_FAIL_BIT = 4;
  localparam logic       RST_SPI_EN   = 1'b1;

  // ------------------------------------------------------------
  // Modes and register selects
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_INIT     = 3'b000,
    MODE_RESTART  = 3'b001,
    MODE_SWFLASH  = 3'b010,
    MODE_NORMAL   = 3'b011,
    MODE_SLEEP    = 3'b100,
    MODE_STOP     = 3'b101,
    MODE_FAILSAFE = 3'b110,
    MODE_READONLY = 3'b111
  } sbcwd_mode_t;

  localparam logic [2:0] SEL_WAKE     = 3'b000;
  localparam logic [2:0] SEL_DEV_FAIL = 3'b001;
  localparam logic [2:0] SEL_COM_FAIL = 3'b010;

endpackage

// >>> hw/sbcwd_shift.sv
// Serial shifter running on the host clock
`timescale 1ns/100ps
module sbcwd_shift
  import sbcwd_pkg::*;
(
  // Link side
  input  wire logic                         sclk,
  input  wire logic                         cs_n,
  input  wire logic                         rst_n,
  input  wire logic                         mosi,
  output logic                              miso,
  // Frozen answer image from the core
  input  wire logic [WORD_W-1:DATA_W]       hdr,
  input  wire logic [NUM_REGS*DATA_W-1:0]   img,
  input  wire logic [2:0]                   prev_sel,
  // Captured frame, stable while deselected
  output logic [WORD_W-1:0]                 word_hold,
  output logic [4:0]                        cnt_hold
);

  logic [WORD_W-1:0] rx_q;
  logic [3:0]        fall_q;
  logic              seen16_q;
  logic              ro_q;
  logic [2:0]        rsel_q;
  logic [3:0]        rise_q;
  logic              run_q;
  logic              miso_q;

  // Next received word and answer selection
  wire  [WORD_W-1:0] rx_d   = {rx_q[WORD_W-2:0], mosi};
  wire  [2:0]        sel    = ro_q ? rsel_q : prev_sel;
  wire  [DATA_W-1:0] data   = img[sel*DATA_W +: DATA_W];
  wire  [WORD_W-1:0] ans    = {hdr, data};
  wire  [3:0]        rise_d = rise_q + 4'h1;
  wire  [3:0]        pos_d  = 4'hF - rise_d;

  // ------------------------------------------------------------
  // Receive side
  // ------------------------------------------------------------
  // sample on falling
  always_ff @(negedge sclk or negedge rst_n) begin
    if (!rst_n) rx_q <= '0;
    else        rx_q <= rx_d;
  end

  // Clock count, cleared between frames
  always_ff @(negedge sclk or posedge cs_n) begin
    if (cs_n) begin
      fall_q   <= 4'h0;
      seen16_q <= 1'b0;
      ro_q     <= 1'b0;
      rsel_q   <= 3'b000;
    end else begin
      fall_q <= fall_q + 4'h1;
      if (fall_q == 4'hF) seen16_q <= 1'b1;
      if (fall_q == HDR_FALL && !seen16_q) begin
        ro_q   <= (rx_d[5:3] == MODE_READONLY);
        rsel_q <= rx_d[2:0];
      end
    end
  end

  // word taken at deselect; the core reads it two clocks later
  always_ff @(posedge cs_n or negedge rst_n) begin
    if (!rst_n) begin
      word_hold <= '0;
      cnt_hold  <= 5'h00;
    end else begin
      word_hold <= rx_q;
      cnt_hold  <= {seen16_q, fall_q};
    end
  end

  // ------------------------------------------------------------
  // Transmit side
  // ------------------------------------------------------------
  // shift out after rising
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      rise_q <= 4'h0;
      run_q  <= 1'b0;
      miso_q <= 1'b0;
    end else begin
      rise_q <= rise_d;
      run_q  <= 1'b1;
      miso_q <= ans[pos_d];
    end
  end

  // First bit must stand before any edge, so it is taken from the image
  assign miso = run_q ? miso_q : ans[WORD_W-1];

endmodule

// >>> hw/sbcwd_top.sv
// Serial control word decoder with wake interrupt register
`timescale 1ns/100ps
module sbcwd_top
  import sbcwd_pkg::*;
(
  // Core clock and reset
  input  wire logic                 CORE_CLK,
  input  wire logic                 RST_N,
  // Serial link from the host
  input  wire logic                 SPI_SCLK,
  input  wire logic                 CHIP_SELECT_N,
  input  wire logic                 SPI_MOSI,
  output logic                      SPI_MISO,
  output logic                      SPI_MISO_OE_N,
  // Wake sources, asynchronous
  input  wire logic                 WAKE_PIN,
  input  wire logic                 CAN_WAKE,
  input  wire logic                 LIN_WAKE,
  input  wire logic                 PERIODIC_WAKE,
  // Mode context, asynchronous
  input  wire logic                 SW_DEV_MODE,
  input  wire logic                 AUTO_INIT,
  input  wire logic                 AUTO_RESTART,
  // Failure register contents from core logic
  input  wire logic [DATA_W-1:0]    DEV_FAIL_STAT,
  input  wire logic [DATA_W-1:0]    COMM_FAIL_STAT,
  // Results
  output logic [2:0]                MODE,
  output logic                      WD_TRIG_LEVEL,
  output logic                      WD_TRIG_STB,
  output logic                      INT_N
);

  // ------------------------------------------------------------
  // Reset release
  // ------------------------------------------------------------
  logic rst_s1_q;
  logic rst_s2_q;

  // Asynchronous assert, synchronous release
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end

  wire rst_n = rst_s2_q;

  // ------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------
  localparam int NSYNC = 8;

  logic [NSYNC-1:0] sy1_q;
  logic [NSYNC-1:0] sy2_q;
  logic [NSYNC-1:0] sy3_q;

  wire [NSYNC-1:0] sy_in = {CHIP_SELECT_N, WAKE_PIN, CAN_WAKE, LIN_WAKE,
                            PERIODIC_WAKE, SW_DEV_MODE, AUTO_INIT, AUTO_RESTART};

  // Third stage only feeds edge detection, never the first
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      sy1_q <= 8'hFF;
      sy2_q <= 8'hFF;
      sy3_q <= 8'hFF;
    end else begin
      sy1_q <= sy_in;
      sy2_q <= sy1_q;
      sy3_q <= sy2_q;
    end
  end

  // Named levels and edges
  wire frame_end  = sy2_q[7] & ~sy3_q[7];
  wire wk_level   = sy2_q[6];
  wire wk_rise    = sy2_q[6] & ~sy3_q[6];
  wire wk_fall    = ~sy2_q[6] & sy3_q[6];
  wire can_ev     = sy2_q[5] & ~sy3_q[5];
  wire lin_ev     = sy2_q[4] & ~sy3_q[4];
  wire cyc_ev     = sy2_q[3] & ~sy3_q[3];
  wire swdev      = sy2_q[2];
  wire auto_init  = sy2_q[1] & ~sy3_q[1];
  wire auto_rst   = sy2_q[0] & ~sy3_q[0];

  // ------------------------------------------------------------
  // Link-side shifter
  // ------------------------------------------------------------
  logic [WORD_W-1:DATA_W]     hdr_q;
  logic [NUM_REGS*DATA_W-1:0] img_q;
  logic [2:0]                 prev_sel_q;
  logic [WORD_W-1:0]          word_hold;
  logic [4:0]                 cnt_hold;
  logic                       miso_w;

  sbcwd_shift u_shift (
    .sclk      (SPI_SCLK),
    .cs_n      (CHIP_SELECT_N),
    .rst_n     (rst_n),
    .mosi      (SPI_MOSI),
    .miso      (miso_w),
    .hdr       (hdr_q),
    .img       (img_q),
    .prev_sel  (prev_sel_q),
    .word_hold (word_hold),
    .cnt_hold  (cnt_hold)
  );

  // Pin driven while selected; enable low means drive
  assign SPI_MISO      = miso_w;
  assign SPI_MISO_OE_N = CHIP_SELECT_N;

  // ------------------------------------------------------------
  // Command decode
  // ------------------------------------------------------------
  logic [2:0] mode_q;

  wire [2:0]        req_mode = word_hold[MODE_HI:MODE_LO];
  wire [2:0]        req_sel  = word_hold[SEL_HI:SEL_LO];
  wire [DATA_W-1:0] req_data = word_hold[DATA_W-1:0];
  wire len_ok   = cnt_hold[4] & (cnt_hold[3:0] == 4'h0);
  wire is_ro    = (req_mode == MODE_READONLY);
  wire is_null  = (req_mode == MODE_INIT);
  wire bad_rst  = (req_mode == MODE_RESTART) & (mode_q != MODE_SWFLASH);
  wire bad_fs   = (req_mode == MODE_FAILSAFE) & ~swdev;
  wire bad_stop = (req_mode == MODE_SWFLASH) & (mode_q == MODE_STOP);
  wire bad_mode = is_null | bad_rst | bad_fs | bad_stop;
  wire accept   = frame_end & len_ok & ~bad_mode;
  wire corrupt  = frame_end & ~(len_ok & ~bad_mode);
  wire do_write = accept & ~is_ro;
  // Register whose content went out in the finished frame
  wire [2:0] shown_sel = is_ro ? req_sel : prev_sel_q;
  wire shown_ok = frame_end & len_ok;
  wire clr_wake = shown_ok & (shown_sel == SEL_WAKE);
  wire clr_dev  = shown_ok & (shown_sel == SEL_DEV_FAIL);
  wire wr_wake  = do_write & (req_sel == SEL_WAKE);
  wire wr_dev   = do_write & (req_sel == SEL_DEV_FAIL);

  // ------------------------------------------------------------
  // Mode register
  // ------------------------------------------------------------
  logic [2:0] mode_d;

  // automatic entries take priority over host requests
  always_comb begin
    mode_d = mode_q;
    if (auto_init) begin
      mode_d = MODE_INIT;
    end else if (auto_rst) begin
      mode_d = MODE_RESTART;
    end else if (do_write) begin
      mode_d = req_mode;
    end
  end

  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) mode_q <= MODE_INIT;
    else        mode_q <= mode_d;
  end

  // ------------------------------------------------------------
  // Watchdog trigger forwarding
  // ------------------------------------------------------------
  logic wd_lvl_q;
  logic wd_stb_q;

  // read-only frames still serve the watchdog
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      wd_lvl_q <= 1'b0;
      wd_stb_q <= 1'b0;
    end else begin
      wd_stb_q <= accept;
      if (accept) wd_lvl_q <= word_hold[BIT_WD];
    end
  end

  // ------------------------------------------------------------
  // Wake interrupt register
  // ------------------------------------------------------------
  logic       can_en_q;
  logic       lin_en_q;
  logic [1:0] edge_sel_q;
  logic       spi_en_q;

  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      can_en_q   <= RST_CAN_EN;
      lin_en_q   <= RST_LIN_EN;
      edge_sel_q <= RST_EDGE;
      spi_en_q   <= RST_SPI_EN;
    end else begin
      if (wr_wake) begin
        can_en_q   <= req_data[CAN_WAKE_ENABLE_BIT];
        lin_en_q   <= req_data[WK_LIN_BIT];
        edge_sel_q <= req_data[WK_EDGE_HI:WK_EDGE_LO];
      end
      if (wr_dev) spi_en_q <= req_data[SPI_FAIL_BIT];
    end
  end

  logic       can_fl_q;
  logic       lin_fl_q;
  logic [1:0] edge_fl_q;
  logic       cyc_fl_q;
  logic       spi_fl_q;

  // Edges seen, filtered by the selection
  wire [1:0] edge_ev = {wk_rise & edge_sel_q[1], wk_fall & edge_sel_q[0]};

  // clear after shift-out; a new event wins over the clear
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      can_fl_q  <= 1'b0;
      lin_fl_q  <= 1'b0;
      edge_fl_q <= 2'b00;
      cyc_fl_q  <= 1'b0;
      spi_fl_q  <= 1'b0;
    end else begin
      can_fl_q  <= can_ev | (can_fl_q & ~clr_wake);
      lin_fl_q  <= lin_ev | (lin_fl_q & ~clr_wake);
      edge_fl_q <= edge_ev | (edge_fl_q & {2{~clr_wake}});
      cyc_fl_q  <= cyc_ev | (cyc_fl_q & ~clr_wake);
      spi_fl_q  <= corrupt | (spi_fl_q & ~clr_dev);
    end
  end

  // ------------------------------------------------------------
  // Read-back images
  // ------------------------------------------------------------
  wire [DATA_W-1:0] spi_mask = DATA_W'(1) << SPI_FAIL_BIT;
  wire [DATA_W-1:0] dev_img  = DEV_FAIL_STAT | (spi_fl_q ? spi_mask : '0);
  wire              summary  = (|dev_img) | (|COMM_FAIL_STAT);
  wire [WK_REG_W-1:0] wake_img = {summary, cyc_fl_q, edge_fl_q, lin_fl_q, can_fl_q};
  wire [NUM_REGS*DATA_W-1:0] img_d = {
    {(NUM_REGS-3)*DATA_W{1'b0}},
    COMM_FAIL_STAT,
    dev_img,
    {(DATA_W-WK_REG_W){1'b0}}, wake_img
  };
  wire [WORD_W-1:DATA_W] hdr_d = {wk_level, mode_q, prev_sel_q};

  logic frz_q;

  // Image frozen one cycle after an accepted frame, so that clears
  // are already visible and nothing moves while a frame may start
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) frz_q <= 1'b0;
    else        frz_q <= accept;
  end

  // corrupted frames leave the previous answer standing
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      prev_sel_q <= SEL_WAKE;
      hdr_q      <= '0;
      img_q      <= '0;
    end else begin
      if (accept) prev_sel_q <= req_sel;
      if (frz_q) begin
        hdr_q <= hdr_d;
        img_q <= img_d;
      end
    end
  end

  // ------------------------------------------------------------
  // Interrupt pin
  // ------------------------------------------------------------
  logic int_n_q;

  wire pend = (can_fl_q & can_en_q) | (lin_fl_q & lin_en_q) | (|edge_fl_q)
            | cyc_fl_q | (spi_fl_q & spi_en_q);

  // held until the cause is read
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) int_n_q <= 1'b1;
    else        int_n_q <= ~pend;
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign MODE          = mode_q;
  assign WD_TRIG_LEVEL = wd_lvl_q;
  assign WD_TRIG_STB   = wd_stb_q;
  assign INT_N         = int_n_q;

endmodule

// >>> tb/sbcwd_top_asserts.sv
// Port-level checker of the serial control word decoder
`timescale 1ns/100ps
module sbcwd_top_asserts
  import sbcwd_pkg::*;
(
  // Clock, reset and link
  input wire logic       CORE_CLK,
  input wire logic       RST_N,
  input wire logic       SPI_SCLK,
  input wire logic       CHIP_SELECT_N,
  input wire logic       SPI_MISO,
  input wire logic       SPI_MISO_OE_N,
  // Context and results
  input wire logic       SW_DEV_MODE,
  input wire logic [2:0] MODE,
  input wire logic       WD_TRIG_LEVEL,
  input wire logic       WD_TRIG_STB,
  input wire logic       INT_N
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);

  // ----------------------------------------
  // Link timing
  // ----------------------------------------
  // Two core samples inside one low half of the serial clock
  sequence s_sclk_low;
    !CHIP_SELECT_N && !SPI_SCLK ##1 !CHIP_SELECT_N && !SPI_SCLK;
  endsequence
  a_miso_held_low:
    assert property (s_sclk_low |-> $stable(SPI_MISO)) else $error("data out moved while clock low");
  a_oe_follows_cs:
    assert property (SPI_MISO_OE_N == CHIP_SELECT_N) else $error("output enable not chip select");
  a_stb_after_deselect:
    assert property (WD_TRIG_STB |-> $past(CHIP_SELECT_N, 2)) else $error("strobe inside a frame");
  a_stb_single_pulse:
    assert property (WD_TRIG_STB |=> !WD_TRIG_STB) else $error("strobe longer than one cycle");
  a_level_with_stb:
    assert property (!$stable(WD_TRIG_LEVEL) |-> WD_TRIG_STB) else $error("trigger level without frame");

  // ----------------------------------------
  // Mode changes and interrupt release
  // ----------------------------------------
  a_auto_modes_only:
    assert property (!$stable(MODE) && !WD_TRIG_STB |-> MODE inside {MODE_INIT, MODE_RESTART})
      else $error("mode changed without request");
  a_restart_from_flash:
    assert property (WD_TRIG_STB && MODE == MODE_RESTART && $past(MODE) != MODE_RESTART
      |-> $past(MODE) == MODE_SWFLASH) else $error("restart not from flash mode");
  a_failsafe_in_dev:
    assert property (MODE == MODE_FAILSAFE && $past(MODE) != MODE_FAILSAFE
      |-> $past(SW_DEV_MODE, 8)) else $error("fail-safe outside development mode");
  a_no_stop_to_flash:
    assert property (MODE == MODE_SWFLASH && WD_TRIG_STB |-> $past(MODE) != MODE_STOP)
      else $error("stop went straight to flash");
  a_int_release_idle:
    assert property ($rose(INT_N) |-> CHIP_SELECT_N) else $error("interrupt released mid frame");
endmodule

bind sbcwd_top sbcwd_top_asserts u_chk (.CORE_CLK(CORE_CLK), .RST_N(RST_N),
  .SPI_SCLK(SPI_SCLK), .CHIP_SELECT_N(CHIP_SELECT_N), .SPI_MISO(SPI_MISO),
  .SPI_MISO_OE_N(SPI_MISO_OE_N), .SW_DEV_MODE(SW_DEV_MODE), .MODE(MODE),
  .WD_TRIG_LEVEL(WD_TRIG_LEVEL), .WD_TRIG_STB(WD_TRIG_STB), .INT_N(INT_N));

// >>> tb/sbcwd_host.sv
// Host serial master model driving the decoder link
`timescale 1ns/100ps
module sbcwd_host (
  // Link
  output logic        sclk,
  output logic        cs_n,
  output logic        mosi,
  input  wire logic   miso,
  // Last answer collected
  output logic [15:0] ans
);
  logic wd;
  event done;

  // Clock stands high and chip is deselected between frames
  initial begin
    sclk = 1'b1;
    cs_n = 1'b1;
    mosi = 1'b0;
    wd = 1'b1;
    ans = 16'h0000;
  end

  // trigger bit alternates on every frame, read-only ones too
  // drive after rise, sample on fall, MSB first
  task automatic xfer(input logic [14:0] c, input int n);
    logic [15:0] w;
    w = {wd, c};
    wd = ~wd;
    ans = 16'h0000;
    #3.7;
    cs_n = 1'b0;
    mosi = w[15];
    #62.5;
    for (int i = 0; i < n; i++) begin
      sclk = 1'b0;
      ans = {ans[14:0], miso};
      #62.5;
      sclk = 1'b1;
      mosi = w[15 - ((i + 1) % 16)];
      #62.5;
    end
    cs_n = 1'b1;
    // Released line shows the inverse so no stale value passes for data
    mosi = ~mosi;
    -> done;
  endtask
endmodule

// >>> tb/sbcwd_top_test.sv
// Self-checking bench of the serial control word decoder
`timescale 1ns/100ps
module sbcwd_top_test
  import sbcwd_pkg::*;
();
  logic        clk, rst_n, sclk, cs_n, mosi, miso, oe_n, wpin, canw, linw, perw;
  logic        dev, ainit, arst, wlev, wstb, int_n, sf, spe, wl_f;
  logic [8:0]  dstat, cstat, r0_f, r1_f, r2_f;
  logic [2:0]  mode, md, md_f, sh_f;
  logic [4:0]  fl;
  logic [3:0]  en;
  logic [15:0] ans;
  logic [15:0] q[$];
  int          n_mismatch, cmp_count;
  int          ml[10] = '{3, 2, 1, 1, 5, 2, 6, 6, 4, 0};

  sbcwd_top dut (.CORE_CLK(clk), .RST_N(rst_n), .SPI_SCLK(sclk), .CHIP_SELECT_N(cs_n),
    .SPI_MOSI(mosi), .SPI_MISO(miso), .SPI_MISO_OE_N(oe_n), .WAKE_PIN(wpin),
    .CAN_WAKE(canw), .LIN_WAKE(linw), .PERIODIC_WAKE(perw), .SW_DEV_MODE(dev),
    .AUTO_INIT(ainit), .AUTO_RESTART(arst), .DEV_FAIL_STAT(dstat),
    .COMM_FAIL_STAT(cstat), .MODE(mode), .WD_TRIG_LEVEL(wlev), .WD_TRIG_STB(wstb),
    .INT_N(int_n));
  sbcwd_host host (.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso), .ans(ans));

  // 125 MHz core clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // ----------------------------------------
  // Compare and report
  // ----------------------------------------
  task automatic chk_word(input logic [15:0] g, input logic [15:0] e);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %0t answer got %h exp %h", $time, g, e);
    end
  endtask
  task automatic chk_pin(input logic [2:0] g, input logic [2:0] e);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %0t output got %h exp %h", $time, g, e);
    end
  endtask
  task automatic test_done();
    $display("Comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Every finished frame takes the oldest noted answer
  always @(host.done) begin
    chk_word(ans, q.pop_front());
  end

  // Hang guard, well beyond the expected run
  initial begin
    #500000;
    n_mismatch++;
    test_done();
  end

  // ----------------------------------------
  // Reference model
  // ----------------------------------------
  function automatic logic [8:0] rd(input logic [2:0] s);
    rd = (s == SEL_WAKE) ? r0_f : (s == SEL_DEV_FAIL) ? r1_f : (s == SEL_COM_FAIL) ? r2_f : 9'h000;
  endfunction
  function automatic logic eint();
    eint = !((|(fl[1:0] & en[1:0])) || (|fl[4:2]) || (sf && spe));
  endfunction
  // Answer image is taken once per accepted frame, not live
  task automatic freeze();
    wl_f = wpin;
    md_f = md;
    r1_f = dstat | {sf, 4'h0};
    r2_f = cstat;
    r0_f = {3'h0, |{r1_f, r2_f}, fl};
  endtask
  task automatic do_reset();
    rst_n = 1'b0;
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    {md, md_f, sh_f, fl, sf, wl_f} = '0;
    {r0_f, r1_f, r2_f} = '0;
    en = 4'hF;
    spe = 1'b1;
    repeat (6) @(negedge clk);
  endtask
  // Note the answer, send the frame, then advance the model
  task automatic frame(input logic [2:0] m, input logic [2:0] s, input logic [8:0] d, input int n);
    logic [2:0] v;
    logic       ok;
    v = (m == MODE_READONLY) ? s : sh_f;
    // Select bits leave before the read-only decision, so they show the frozen select
    q.push_back({wl_f, md_f, sh_f, rd(v)} >> (16 - n));
    host.xfer({m, s, d}, n);
    repeat (8) @(negedge clk);
    ok = n > 0 && n % 16 == 0 && m != MODE_INIT && !(m == MODE_RESTART && md != MODE_SWFLASH)
      && !(m == MODE_FAILSAFE && !dev) && !(m == MODE_SWFLASH && md == MODE_STOP);
    if (n > 0 && n % 16 == 0 && v == SEL_WAKE) fl = 5'h00;
    if (n > 0 && n % 16 == 0 && v == SEL_DEV_FAIL) sf = 1'b0;
    if (!ok) begin
      sf = 1'b1;
    end else begin
      if (m != MODE_READONLY) md = m;
      if (m != MODE_READONLY && s == SEL_WAKE) en = d[3:0];
      if (m != MODE_READONLY && s == SEL_DEV_FAIL) spe = d[SPI_FAIL_BIT];
      sh_f = s;
      freeze();
    end
    chk_pin(mode, md);
    chk_pin({2'b00, int_n}, {2'b00, eint()});
  endtask

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    {rst_n, canw, linw, perw, dev, ainit, arst} = '0;
    wpin = 1'b1;
    {dstat, cstat} = '0;
    void'($urandom(21));
    do_reset();
    // Read-only sweep of every select after reset, cleared image expected
    for (int s = 0; s < 8; s++) frame(3'(MODE_READONLY), 3'(s), 9'($urandom), 16);
    $display("defaults test done");
    // Every mode code but read-only, legal and refused, random enables written
    for (int i = 0; i < 10; i++) begin
      dev = (i >= 7);
      frame(3'(ml[i]), SEL_WAKE, 9'($urandom), 16);
    end
    arst = 1'b1;
    repeat (6) @(negedge clk);
    md = MODE_RESTART;
    chk_pin(mode, md);
    ainit = 1'b1;
    repeat (6) @(negedge clk);
    md = MODE_INIT;
    chk_pin(mode, md);
    {arst, ainit} = 2'b00;
    $display("mode test done");
    // Wake sources, edge selection and release by reading
    frame(MODE_NORMAL, SEL_WAKE, 9'h00F, 16);
    frame(MODE_READONLY, SEL_DEV_FAIL, 9'h000, 16);
    {canw, linw, perw} = 3'b111;
    repeat (4) @(negedge clk);
    {canw, linw, perw} = 3'b000;
    wpin = 1'b0;
    repeat (8) @(negedge clk);
    fl = 5'h17;
    chk_pin({2'b00, int_n}, 3'h0);
    frame(MODE_NORMAL, SEL_WAKE, 9'h000, 16);
    wpin = 1'b1;
    repeat (8) @(negedge clk);
    frame(MODE_NORMAL, SEL_DEV_FAIL, 9'h010, 16);
    canw = 1'b1;
    repeat (4) @(negedge clk);
    canw = 1'b0;
    repeat (8) @(negedge clk);
    fl[0] = 1'b1;
    chk_pin({2'b00, int_n}, 3'h1);
    $display("wake test done");
    // Wrong clock counts, serial fail seen at the interrupt pin, then summary read back
    dstat = 9'($urandom);
    cstat = 9'($urandom);
    frame(MODE_NORMAL, SEL_WAKE, 9'h000, 15);
    frame(MODE_NORMAL, SEL_WAKE, 9'h000, 0);
    frame(MODE_NORMAL, SEL_WAKE, 9'h00F, 16);
    frame(MODE_READONLY, SEL_WAKE, 9'h000, 16);
    frame(MODE_READONLY, SEL_DEV_FAIL, 9'h000, 16);
    frame(MODE_READONLY, SEL_COM_FAIL, 9'h000, 16);
    {dstat, cstat} = '0;
    $display("clock count test done");
    // Reset in mid-run returns to the cleared state
    frame(MODE_NORMAL, SEL_COM_FAIL, 9'h000, 16);
    do_reset();
    chk_pin(mode, md);
    frame(MODE_READONLY, SEL_WAKE, 9'h000, 16);
    $display("second reset test done");
    test_done();
  end
endmodule
